// *** src/line_sync2.v ***
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Two-stage synchronizer for one modem input line
// ----------------------------------------------------------------------
module line_sync2
(
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire q
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // line_sync2

// *** src/modem_lines.v ***
// Functional notes
// [R01] Clear-to-send line, active low, reads as status bit 4.
// [R02] Data-set-ready line, active low, reads as status bit 5.
// [R03] Data-carrier-detect line, active low, reads as status bit 7.
// [R04] Ring-indicator line, active low, reads as status bit 6.
// [R05] Data-terminal-ready output, active low, follows control bit 0. Held inactive while loopback bit 4 is set.
// [R06] Request-to-send output, active low, follows control bit 1. Held inactive while loopback bit 4 is set.
// [R07] Every modem input passes a two-stage synchronizer before status.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "modem_lines_defs.vh"

module modem_lines
(
  input  wire                 REF_CLK,
  input  wire                 RESET_N,
  input  wire                 WB_CYC_I,
  input  wire                 WB_STB_I,
  input  wire                 WB_WE_I,
  input  wire [`ADR_W-1:0]    WB_ADR_I,
  input  wire [`SEL_W-1:0]    WB_SEL_I,
  input  wire [`DAT_W-1:0]    WB_DAT_I,
  output reg  [`DAT_W-1:0]    WB_DAT_O,
  output reg                  WB_ACK_O,
  input  wire                 CTS_N,
  input  wire                 DSR_N,
  input  wire                 RI_N,
  input  wire                 DCD_N,
  output reg                  DTR_N,
  output reg                  RTS_N
);

  // --------------------------------------------------------------------
  // Address decode helper
  // --------------------------------------------------------------------
  function hit;
    input [`ADR_W-1:0] adr;
    input [`ADR_W-1:0] off;
    begin
      hit = (adr == off);
    end
  endfunction

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  wire [`LINES-1:0]   line_n;
  wire [`LINES-1:0]   line_sync_n;
  wire [`LINES-1:0]   pin_level;
  reg  [`LINES-1:0]   loop_level;
  wire [`LINES-1:0]   level;
  reg  [`LINES-1:0]   level_prev_reg;
  wire [`LINES-1:0]   change;
  reg  [`LINES-1:0]   delta_reg;
  reg  [`LINES-1:0]   delta_next;
  reg  [`CTRL_W-1:0]  ctrl_reg;
  reg  [`CTRL_W-1:0]  ctrl_next;
  reg  [`BYTE_W-1:0]  scratch_reg;
  reg  [`BYTE_W-1:0]  scratch_next;
  wire [`STAT_W-1:0]  status;
  reg  [`BYTE_W-1:0]  read_byte;
  wire                take;
  wire                take_wr;
  wire                take_rd;

  assign line_n[`LINE_CTS] = CTS_N;
  assign line_n[`LINE_DSR] = DSR_N;
  assign line_n[`LINE_RI]  = RI_N;
  assign line_n[`LINE_DCD] = DCD_N;

  // --------------------------------------------------------------------
  // Input synchronizers
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `LINES; gi = gi + 1)
    begin : g_sync
      line_sync2 u_sync
      (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .d     (line_n[gi]),
        .q     (line_sync_n[gi])
      ); // see [R07]
      assign pin_level[gi] = ~line_sync_n[gi];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Loopback source: outputs fed back to inputs
  // --------------------------------------------------------------------
  always @*
  begin
    loop_level               = `LINES_NONE;
    loop_level[`LINE_CTS]    = ctrl_reg[`CTRL_RTS];
    loop_level[`LINE_DSR]    = ctrl_reg[`CTRL_DTR];
    loop_level[`LINE_RI]     = ctrl_reg[`CTRL_AUX1];
    loop_level[`LINE_DCD]    = ctrl_reg[`CTRL_AUX2];
  end

  assign level = ctrl_reg[`CTRL_LOOP] ? loop_level : pin_level;

  // --------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------
  generate
    for (gi = 0; gi < `LINES; gi = gi + 1)
    begin : g_change
      if (gi == `LINE_RI)
      begin : g_trail
        // Ring counts only when the ring ends
        assign change[gi] = level_prev_reg[gi] & ~level[gi];
      end
      else
      begin : g_any
        assign change[gi] = level_prev_reg[gi] ^ level[gi];
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------
  assign status[`STAT_DCTS] = delta_reg[`LINE_CTS];
  assign status[`STAT_DDSR] = delta_reg[`LINE_DSR];
  assign status[`STAT_TERI] = delta_reg[`LINE_RI];
  assign status[`STAT_DDCD] = delta_reg[`LINE_DCD];
  assign status[`STAT_CTS]  = level[`LINE_CTS]; // see [R01]
  assign status[`STAT_DSR]  = level[`LINE_DSR]; // see [R02]
  assign status[`STAT_RI]   = level[`LINE_RI];  // see [R04]
  assign status[`STAT_DCD]  = level[`LINE_DCD]; // see [R03]

  // --------------------------------------------------------------------
  // Bus request taking
  // --------------------------------------------------------------------
  assign take    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign take_wr = take & WB_WE_I;
  assign take_rd = take & ~WB_WE_I;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always @*
  begin
    ctrl_next = ctrl_reg;
    if (take_wr && WB_SEL_I[0] && hit(WB_ADR_I, `ADR_MODEM_CTRL))
    begin
      ctrl_next = WB_DAT_I[`CTRL_W-1:0];
    end
  end

  always @*
  begin
    scratch_next = scratch_reg;
    if (take_wr && WB_SEL_I[0] && hit(WB_ADR_I, `ADR_SCRATCH))
    begin
      scratch_next = WB_DAT_I[`BYTE_W-1:0];
    end
  end

  // A change in the reading cycle survives the clear
  always @*
  begin
    delta_next = delta_reg;
    if (take_rd && hit(WB_ADR_I, `ADR_MODEM_STAT))
    begin
      delta_next = `LINES_NONE;
    end
    delta_next = delta_next | change;
  end

  always @*
  begin
    read_byte = {`BYTE_W{1'b0}};
    if (hit(WB_ADR_I, `ADR_MODEM_CTRL))
    begin
      read_byte = {{(`BYTE_W-`CTRL_W){1'b0}}, ctrl_reg};
    end
    else if (hit(WB_ADR_I, `ADR_MODEM_STAT))
    begin
      read_byte = status;
    end
    else if (hit(WB_ADR_I, `ADR_SCRATCH))
    begin
      read_byte = scratch_reg;
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_reg       <= `CTRL_RESET;
      scratch_reg    <= `SCRATCH_RESET;
      delta_reg      <= `LINES_NONE;
      level_prev_reg <= `LINES_NONE;
    end
    else
    begin
      ctrl_reg       <= ctrl_next;
      scratch_reg    <= scratch_next;
      delta_reg      <= delta_next;
      level_prev_reg <= level;
    end
  end

  // --------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------
  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `DAT_ZERO;
    end
    else
    begin
      WB_ACK_O <= take;
      if (take_rd)
      begin
        WB_DAT_O <= {`READ_PAD, read_byte};
      end
    end
  end

  // --------------------------------------------------------------------
  // Modem outputs, held inactive in loopback
  // --------------------------------------------------------------------
  always @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DTR_N <= 1'b1;
      RTS_N <= 1'b1;
    end
    else
    begin
      DTR_N <= ~(ctrl_next[`CTRL_DTR] & ~ctrl_next[`CTRL_LOOP]); // see [R05]
      RTS_N <= ~(ctrl_next[`CTRL_RTS] & ~ctrl_next[`CTRL_LOOP]); // see [R06]
    end
  end

endmodule // modem_lines

// *** src/modem_lines_defs.vh ***
`ifndef MODEM_LINES_DEFS_VH
`define MODEM_LINES_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADR_W             4
`define ADR_MODEM_CTRL    4'h0
`define ADR_MODEM_STAT    4'h4
`define ADR_SCRATCH       4'h8

// ----------------------------------------------------------------------
// Modem control register fields
// ----------------------------------------------------------------------
`define CTRL_W            5
`define CTRL_DTR          0
`define CTRL_RTS          1
`define CTRL_AUX1         2
`define CTRL_AUX2         3
`define CTRL_LOOP         4
`define CTRL_RESET        5'h00

// ----------------------------------------------------------------------
// Modem status register fields
// ----------------------------------------------------------------------
`define STAT_W            8
`define STAT_DCTS         0
`define STAT_DDSR         1
`define STAT_TERI         2
`define STAT_DDCD         3
`define STAT_CTS          4
`define STAT_DSR          5
`define STAT_RI           6
`define STAT_DCD          7

// ----------------------------------------------------------------------
// Line indices, reset levels, bus widths
// ----------------------------------------------------------------------
`define LINES             4
`define LINE_CTS          0
`define LINE_DSR          1
`define LINE_RI           2
`define LINE_DCD          3
`define LINE_IDLE         1'b1
`define LINES_NONE        4'h0
`define DAT_W             32
`define SEL_W             4
`define BYTE_W            8
`define READ_PAD          24'h000000
`define SCRATCH_RESET     8'h00
`define DAT_ZERO          32'h00000000

`endif

// *** test/modem_lines_sva.sv ***
`timescale 1ns/1ns
module modem_lines_sva
(
  input logic        REF_CLK,
  input logic        RESET_N,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [3:0]  WB_ADR_I,
  input logic [3:0]  WB_SEL_I,
  input logic [31:0] WB_DAT_I,
  input logic [31:0] WB_DAT_O,
  input logic        WB_ACK_O,
  input logic        CTS_N,
  input logic        DSR_N,
  input logic        RI_N,
  input logic        DCD_N,
  input logic        DTR_N,
  input logic        RTS_N
);
  logic [3:0] p1, p2, p3;
  logic       rd_q;
  logic       loop_q;
  wire        req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire        wr_c = req && WB_WE_I && WB_ADR_I == 4'h0 && WB_SEL_I[0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ----------
  // Pin history, mirrors the reset level of the synchronizer
  // ----------
  always @(posedge REF_CLK or negedge RESET_N)
    if (!RESET_N)
      {loop_q, rd_q, p3, p2, p1} <= {2'b00, 12'hFFF};
    else
    begin
      {rd_q, p3, p2, p1} <= {req && !WB_WE_I && WB_ADR_I == 4'h4, p2, p1,
                             DCD_N, RI_N, DSR_N, CTS_N};
      if (wr_c)
        loop_q <= WB_DAT_I[4];
    end
  a_cts_status: assert property (!loop_q && rd_q && WB_ACK_O |-> WB_DAT_O[4] == !p3[0])
    else $error("CTS status bit wrong");
  a_dsr_status: assert property (!loop_q && rd_q && WB_ACK_O |-> WB_DAT_O[5] == !p3[1])
    else $error("DSR status bit wrong");
  a_dcd_status: assert property (!loop_q && rd_q && WB_ACK_O |-> WB_DAT_O[7] == !p3[3])
    else $error("DCD status bit wrong");
  a_ri_status: assert property (!loop_q && rd_q && WB_ACK_O |-> WB_DAT_O[6] == !p3[2])
    else $error("RI status bit wrong");
  a_dtr_follow: assert property (WB_ACK_O && $past(wr_c) && !$past(WB_DAT_I[4])
    |-> DTR_N == !$past(WB_DAT_I[0])) else $error("DTR output wrong");
  a_dtr_cause: assert property ($changed(DTR_N) |-> $past(wr_c))
    else $error("DTR moved without write");
  a_rts_follow: assert property (wr_c && !WB_DAT_I[4] |=> RTS_N == !$past(WB_DAT_I[1]))
    else $error("RTS output wrong");
  a_sync_lag: assert property (!loop_q && rd_q && WB_ACK_O && p2 != p3
    |-> WB_DAT_O[7:4] == ~p3) else $error("Status not two stages late");
  a_loop_quiet: assert property (loop_q |-> DTR_N && RTS_N)
    else $error("Modem outputs active in loopback");
endmodule // modem_lines_sva

bind modem_lines modem_lines_sva modem_lines_sva_i
(
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CTS_N(CTS_N), .DSR_N(DSR_N),
  .RI_N(RI_N), .DCD_N(DCD_N), .DTR_N(DTR_N), .RTS_N(RTS_N)
);

// *** test/modem_lines_tb.sv ***
`timescale 1ns/1ns
module modem_lines_tb;
  logic        clk, rst_n, cyc, stb, we, ack, dtr_n, rts_n, cts_n, dsr_n, ri_n, dcd_n;
  logic [3:0]  adr, sel, want;
  logic [31:0] dat, rdat, q;
  integer      failures, checks_done, i;

  modem_lines modem_lines_i (.REF_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n),
    .DTR_N(dtr_n), .RTS_N(rts_n));
  modem_partner modem_partner_i (.want(want), .dtr_n(dtr_n), .rts_n(rts_n), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task final_report;
  begin
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
  begin
    checks_done = checks_done + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask

  // ----------
  // Classic Wishbone single cycle
  // ----------
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer n;
  begin
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    n = 0;
    do
    begin
      @(posedge clk);
      n = n + 1;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20)
    begin
      failures = failures + 1;
      final_report;
    end
  end
  endtask

  initial
  begin
    {rst_n, cyc, stb, we} = 4'h0;
    {adr, sel, want} = 12'h000;
    dat = 32'h00000000;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk(dtr_n, 1'b1);
    chk(rts_n, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:0], 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1'b1, 4'h0, i);
      chk(dtr_n, !i[0]);
      chk(rts_n, !i[1]);
    end
    $display("output test done");
    for (i = 0; i < 16; i = i + 1)
    begin
      want <= i[3:0];
      repeat (4) @(posedge clk);
      wb(1'b0, 4'h4, 32'h0);
      chk(q[4], i[0]);
      chk(q[5], i[1]);
      chk(q[6], i[2]);
      chk(q[7], i[3]);
    end
    wb(1'b1, 4'h0, 32'h1);
    repeat (4) @(posedge clk);
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:4], 4'hE);
    $display("status test done");
    wb(1'b1, 4'h0, 32'h3);
    want <= 4'h1;
    repeat (4) @(posedge clk);
    want <= 4'hE;
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:4], 4'h1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:4], 4'hE);
    $display("sync test done");
    wb(1'b1, 4'h0, 32'h1F);
    chk(dtr_n, 1'b1);
    chk(rts_n, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:4], 4'hF);
    wb(1'b1, 4'h0, 32'h14);
    wb(1'b0, 4'h4, 32'h0);
    chk(q[7:4], 4'h4);
    wb(1'b1, 4'h0, 32'h3);
    chk(dtr_n, 1'b0);
    chk(rts_n, 1'b0);
    $display("loopback test done");
    final_report;
  end
endmodule // modem_lines_tb

// *** test/modem_partner.sv ***
`timescale 1ns/1ns
// ----------
// Modem: answers RTS with CTS, DTR with DSR
// ----------
module modem_partner
(
  input  logic [3:0] want,
  input  logic       dtr_n,
  input  logic       rts_n,
  output logic       cts_n,
  output logic       dsr_n,
  output logic       ri_n,
  output logic       dcd_n
);
  assign cts_n = ~(want[0] & ~rts_n);
  assign dsr_n = ~(want[1] & ~dtr_n);
  assign ri_n  = ~want[2];
  assign dcd_n = ~want[3];
endmodule // modem_partner
